// ===== include/sls_pkg.sv
// Package for the signal limit supervisor: register map, field
// layout, reset values, mode and action codes, timing constants.
// Assumes a 10 MHz core clock and a 32-bit register port.
package sls_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] SLS_OFS_CTRL   = 8'h00; // Mode and action
  localparam logic [7:0] SLS_OFS_LOW    = 8'h04; // Low limit
  localparam logic [7:0] SLS_OFS_HIGH   = 8'h08; // High limit
  localparam logic [7:0] SLS_OFS_HYST   = 8'h0C; // Hysteresis
  localparam logic [7:0] SLS_OFS_OFFDLY = 8'h10; // Deactivation delay
  localparam logic [7:0] SLS_OFS_STATE  = 8'h14; // Live state
  localparam logic [7:0] SLS_OFS_IRQSTS = 8'h18; // Sticky events
  localparam logic [7:0] SLS_OFS_IRQMSK = 8'h1C; // Event mask

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int SLS_CTRL_MODE_LSB = 0;  // Mode in bits 3:0
  localparam int SLS_CTRL_ACT_LSB  = 4;  // Action in bits 5:4
  localparam int SLS_ST_CNT_LSB    = 16; // Delay count in bits 30:16
  localparam int SLS_DLY_W         = 15; // Up to 32767 counts
  localparam int SLS_IRQ_W         = 2;  // Assert and release events
  localparam int SLS_IRQ_ON        = 0;  // Action asserted event
  localparam int SLS_IRQ_OFF       = 1;  // Action released event

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0]          SLS_RST_LIMIT  = 32'h0000_0000;
  localparam logic [30:0]          SLS_RST_HYST   = 31'h0000_0000;
  localparam logic [SLS_DLY_W-1:0] SLS_RST_OFFDLY = 15'h0000;
  localparam logic [SLS_IRQ_W-1:0] SLS_RST_IRQ    = 2'h0;

  // ----------------------------------------------------------------
  // Timing: one delay count is a tenth of a second
  // ----------------------------------------------------------------
  localparam int SLS_CLK_PERIOD_NS = 100;         // 10 MHz core clock
  localparam int SLS_DLY_STEP_NS   = 100_000_000; // 0.1 s per count
  localparam int SLS_DLY_STEP_CYC  = SLS_DLY_STEP_NS / SLS_CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SLS_MODE_OFF      = 4'h0, // Channel unused
    SLS_MODE_LOW      = 4'h1,
    SLS_MODE_HIGH     = 4'h2,
    SLS_MODE_ABS_LOW  = 4'h3,
    SLS_MODE_ABS_HIGH = 4'h4,
    SLS_MODE_BOTH     = 4'h5,
    SLS_MODE_ABS_BOTH = 4'h6,
    SLS_MODE_HYST     = 4'h7,
    SLS_MODE_FALL     = 4'h8, // Low falling crossing
    SLS_MODE_RISE     = 4'h9  // High rising crossing
  } sls_mode_t;

  typedef enum logic [1:0] {
    SLS_ACT_NONE      = 2'h0,
    SLS_ACT_WARN      = 2'h1,
    SLS_ACT_FAULT     = 2'h2,
    SLS_ACT_FAULT_RUN = 2'h3
  } sls_act_t;

  typedef struct packed {
    logic [7:0]  addr;  // Byte address
    logic [31:0] wdata; // Write data
    logic        wr;    // Write strobe
    logic        rd;    // Read strobe
  } sls_bus_t;

endpackage

// ===== verilog/sls_supervisor.sv
// Single signal supervision channel with hysteresis and off delay.
// Assumes value, start and run inputs come from logic on core_clk_i,
// and a master on the register port that never waits.
`timescale 1ns/100ps

module sls_supervisor
  import sls_pkg::*;
#(
  parameter int TICK_CYCLES = SLS_DLY_STEP_CYC // Cycles per delay count
)(
  input  wire logic        core_clk_i,    // 10 MHz core clock
  input  wire logic        rst_i,         // Async reset, active high
  input  wire sls_bus_t    bus_i,         // Register port request
  output logic [31:0]      rdata_o,       // Read data, cycle after read
  input  wire logic [31:0] value_i,       // Monitored value, signed
  input  wire logic        value_vld_i,   // Evaluation strobe
  input  wire logic        motor_start_i, // Motor start event pulse
  input  wire logic        running_i,     // Motor running level
  output logic             status_o,      // Supervision status
  output logic             warn_o,        // Warning request
  output logic             fault_o,       // Fault trip request
  output logic             irq_o          // Level interrupt
);

  // ----------------------------------------------------------------
  // Local types and constants
  // ----------------------------------------------------------------
  localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // Comparison width: doubled 32-bit value plus hysteresis, no overflow
  typedef logic signed [34:0] sls_cmp_t;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  sls_mode_t             mode_ff;      // Comparison mode
  sls_act_t              act_sel_ff;   // Action selector
  logic [31:0]           low_ff;       // Low limit
  logic [31:0]           high_ff;      // High limit
  logic [30:0]           hyst_ff;      // Hysteresis, non-negative
  logic [SLS_DLY_W-1:0]  offdly_ff;    // Off delay in tenths
  logic [SLS_IRQ_W-1:0]  irq_sts_ff;   // Sticky events
  logic [SLS_IRQ_W-1:0]  irq_msk_ff;   // Event mask
  logic [31:0]           rdata_ff;     // Read data

  // ----------------------------------------------------------------
  // Supervision state
  // ----------------------------------------------------------------
  logic                  cond_ff;      // Raw comparison result
  logic                  armed_ff;     // Crossing modes: start side seen
  logic                  act_ff;       // Action after off delay
  logic                  dly_run_ff;   // Off delay counting
  logic [SLS_DLY_W-1:0]  dly_cnt_ff;   // Remaining delay counts
  logic [TICK_W-1:0]     tick_cnt_ff;  // Divider for delay counts
  logic                  warn_ff;      // Registered warning
  logic                  fault_ff;     // Registered fault

  logic                  ctrl_wr;      // Write to the control word
  logic                  tick;         // One-cycle delay-count enable
  logic                  nxt_cond;     // Next raw comparison result
  logic                  nxt_armed;    // Next arming state
  logic [SLS_IRQ_W-1:0]  irq_evt;      // Events of this cycle
  logic                  mode_cross;   // Mode is a crossing mode

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  assign ctrl_wr = bus_i.wr && (bus_i.addr == SLS_OFS_CTRL);

  // Configuration registers
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_ff    <= SLS_MODE_OFF;
      act_sel_ff <= SLS_ACT_NONE;
      low_ff     <= SLS_RST_LIMIT;
      high_ff    <= SLS_RST_LIMIT;
      hyst_ff    <= SLS_RST_HYST;
      offdly_ff  <= SLS_RST_OFFDLY;
      irq_msk_ff <= SLS_RST_IRQ;
    end
    else if (bus_i.wr)
    begin
      if (bus_i.addr == SLS_OFS_CTRL)
      begin
        mode_ff    <= sls_mode_t'(bus_i.wdata[SLS_CTRL_MODE_LSB +: 4]);
        act_sel_ff <= sls_act_t'(bus_i.wdata[SLS_CTRL_ACT_LSB +: 2]);
      end
      else if (bus_i.addr == SLS_OFS_LOW)
      begin
        low_ff <= bus_i.wdata;
      end
      else if (bus_i.addr == SLS_OFS_HIGH)
      begin
        high_ff <= bus_i.wdata;
      end
      else if (bus_i.addr == SLS_OFS_HYST)
      begin
        // Top bit dropped so the band is never negative
        hyst_ff <= bus_i.wdata[30:0];
      end
      else if (bus_i.addr == SLS_OFS_OFFDLY)
      begin
        offdly_ff <= bus_i.wdata[SLS_DLY_W-1:0];
      end
      else if (bus_i.addr == SLS_OFS_IRQMSK)
      begin
        irq_msk_ff <= bus_i.wdata[SLS_IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port, data valid only in the cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_ff <= 32'h0000_0000;
    end
    else if (!bus_i.rd)
    begin
      rdata_ff <= 32'h0000_0000; // Bus idle reads as zero
    end
    else if (bus_i.addr == SLS_OFS_CTRL)
    begin
      rdata_ff <= {26'h000_0000, act_sel_ff, mode_ff};
    end
    else if (bus_i.addr == SLS_OFS_LOW)
    begin
      rdata_ff <= low_ff;
    end
    else if (bus_i.addr == SLS_OFS_HIGH)
    begin
      rdata_ff <= high_ff;
    end
    else if (bus_i.addr == SLS_OFS_HYST)
    begin
      rdata_ff <= {1'b0, hyst_ff};
    end
    else if (bus_i.addr == SLS_OFS_OFFDLY)
    begin
      rdata_ff <= {17'h0_0000, offdly_ff};
    end
    else if (bus_i.addr == SLS_OFS_STATE)
    begin
      // Live state: action, raw result, armed, delay left
      rdata_ff <= {1'b0, dly_cnt_ff, 12'h000, dly_run_ff, armed_ff, cond_ff, act_ff};
    end
    else if (bus_i.addr == SLS_OFS_IRQSTS)
    begin
      rdata_ff <= {30'h0000_0000, irq_sts_ff};
    end
    else if (bus_i.addr == SLS_OFS_IRQMSK)
    begin
      rdata_ff <= {30'h0000_0000, irq_msk_ff};
    end
    else
    begin
      rdata_ff <= 32'h0000_0000; // Unmapped address
    end
  end

  // ----------------------------------------------------------------
  // Thresholds, all doubled so half the hysteresis stays exact
  // ----------------------------------------------------------------
  function automatic sls_cmp_t dbl(input logic signed [31:0] x, input logic mag);
    sls_cmp_t t;
    t = sls_cmp_t'(x);
    if (mag && t < 0)
    begin
      t = -t; // Magnitude of the most negative value still fits
    end
    return sls_cmp_t'(t <<< 1);
  endfunction

  sls_cmp_t h;       // Full hysteresis equals twice the half band
  sls_cmp_t v2;      // Doubled value, signed or magnitude
  sls_cmp_t lo_dn;   // Low limit minus half band
  sls_cmp_t lo_up;   // Low limit plus half band
  sls_cmp_t hi_dn;   // High limit minus half band
  sls_cmp_t hi_up;   // High limit plus half band
  logic     use_mag; // Abs modes compare magnitudes

  assign use_mag = (mode_ff == SLS_MODE_ABS_LOW) || (mode_ff == SLS_MODE_ABS_HIGH) ||
                   (mode_ff == SLS_MODE_ABS_BOTH);
  assign h       = sls_cmp_t'(hyst_ff);
  assign v2      = dbl(value_i, use_mag);
  assign lo_dn   = dbl(low_ff, use_mag) - h;
  assign lo_up   = dbl(low_ff, use_mag) + h;
  assign hi_dn   = dbl(high_ff, use_mag) - h;
  assign hi_up   = dbl(high_ff, use_mag) + h;

  assign mode_cross = (mode_ff == SLS_MODE_FALL) || (mode_ff == SLS_MODE_RISE);

  // ----------------------------------------------------------------
  // Comparison per mode; between thresholds the result holds
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_cond  = cond_ff;
    nxt_armed = armed_ff;
    case (mode_ff)
      SLS_MODE_LOW, SLS_MODE_ABS_LOW:
      begin
        if (v2 < lo_dn)
          nxt_cond = 1'b1;
        else if (v2 > lo_up)
          nxt_cond = 1'b0;
      end
      SLS_MODE_HIGH, SLS_MODE_ABS_HIGH:
      begin
        if (v2 > hi_up)
          nxt_cond = 1'b1;
        else if (v2 < hi_dn)
          nxt_cond = 1'b0;
      end
      SLS_MODE_BOTH, SLS_MODE_ABS_BOTH:
      begin
        // Outside wins when a narrow window makes bands overlap
        if ((v2 > hi_up) || (v2 < lo_dn))
          nxt_cond = 1'b1;
        else if ((v2 < hi_dn) && (v2 > lo_up))
          nxt_cond = 1'b0;
      end
      SLS_MODE_HYST:
      begin
        if (v2 > hi_up)
          nxt_cond = 1'b1;
        else if (v2 < lo_dn)
          nxt_cond = 1'b0;
      end
      SLS_MODE_FALL:
      begin
        // Arm above the band, fire only when armed and below
        if (v2 > lo_up)
        begin
          nxt_armed = 1'b1;
          nxt_cond  = 1'b0;
        end
        else if (v2 < lo_dn)
        begin
          nxt_cond  = cond_ff || armed_ff;
          nxt_armed = 1'b0;
        end
      end
      SLS_MODE_RISE:
      begin
        if (v2 < hi_dn)
        begin
          nxt_armed = 1'b1;
          nxt_cond  = 1'b0;
        end
        else if (v2 > hi_up)
        begin
          nxt_cond  = cond_ff || armed_ff;
          nxt_armed = 1'b0;
        end
      end
      default:
      begin
        nxt_cond  = 1'b0;
        nxt_armed = 1'b0;
      end
    endcase
  end

  // Raw result, evaluated once per value strobe
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cond_ff  <= 1'b0;
      armed_ff <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      cond_ff  <= 1'b0;
      armed_ff <= 1'b0;
    end
    else if (motor_start_i && mode_cross)
    begin
      cond_ff  <= 1'b0;
      armed_ff <= nxt_armed && value_vld_i;
    end
    else if (value_vld_i)
    begin
      cond_ff  <= nxt_cond;
      armed_ff <= nxt_armed;
    end
  end

  // ----------------------------------------------------------------
  // Delay-count divider, restarted on each delay load
  // ----------------------------------------------------------------
  assign tick = (tick_cnt_ff == TICK_LAST);

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tick_cnt_ff <= '0;
    end
    else if (!dly_run_ff || tick)
    begin
      tick_cnt_ff <= '0; // Full first count after load
    end
    else
    begin
      tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Action with off delay; reassertion aborts the countdown
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      act_ff     <= 1'b0;
      dly_run_ff <= 1'b0;
      dly_cnt_ff <= '0;
    end
    else if (ctrl_wr || (motor_start_i && mode_cross))
    begin
      // Start clears at once, the off delay does not apply
      act_ff     <= 1'b0;
      dly_run_ff <= 1'b0;
      dly_cnt_ff <= '0;
    end
    else if (cond_ff)
    begin
      act_ff     <= 1'b1;
      dly_run_ff <= 1'b0;
      dly_cnt_ff <= '0;
    end
    else if (act_ff && !dly_run_ff)
    begin
      if (offdly_ff == '0)
      begin
        act_ff <= 1'b0;
      end
      else
      begin
        dly_run_ff <= 1'b1;
        dly_cnt_ff <= offdly_ff;
      end
    end
    else if (dly_run_ff && tick)
    begin
      if (dly_cnt_ff == SLS_DLY_W'(1))
      begin
        act_ff     <= 1'b0;
        dly_run_ff <= 1'b0;
      end
      dly_cnt_ff <= dly_cnt_ff - SLS_DLY_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Action mapping; status itself never depends on it
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      warn_ff  <= 1'b0;
      fault_ff <= 1'b0;
    end
    else
    begin
      warn_ff  <= act_ff && (act_sel_ff == SLS_ACT_WARN);
      fault_ff <= act_ff && ((act_sel_ff == SLS_ACT_FAULT) ||
                  ((act_sel_ff == SLS_ACT_FAULT_RUN) && running_i));
    end
  end

  // ----------------------------------------------------------------
  // Interrupts: set wins over a write-one clear
  // ----------------------------------------------------------------
  assign irq_evt[SLS_IRQ_ON]  = cond_ff && !act_ff && !ctrl_wr && !(motor_start_i && mode_cross);
  assign irq_evt[SLS_IRQ_OFF] = act_ff && !cond_ff && !dly_run_ff && (offdly_ff == '0)
                                || (dly_run_ff && tick && !cond_ff && (dly_cnt_ff == SLS_DLY_W'(1)));

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_sts_ff <= SLS_RST_IRQ;
    end
    else if (bus_i.wr && (bus_i.addr == SLS_OFS_IRQSTS))
    begin
      irq_sts_ff <= (irq_sts_ff & ~bus_i.wdata[SLS_IRQ_W-1:0]) | irq_evt;
    end
    else
    begin
      irq_sts_ff <= irq_sts_ff | irq_evt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o  = rdata_ff;
  assign status_o = act_ff;
  assign warn_o   = warn_ff;
  assign fault_o  = fault_ff;
  assign irq_o    = |(irq_sts_ff & irq_msk_ff);

endmodule

// ===== testbench/sls_supervisor_properties.sv
// Port-level checker for the signal limit supervisor.
// Assumes binding to sls_supervisor; CTRL is shadowed from bus writes.
`timescale 1ns/100ps

module sls_checker
  import sls_pkg::*;
(
  input  wire logic        core_clk_i,    // Core clock
  input  wire logic        rst_i,         // Async reset
  input  wire sls_bus_t    bus_i,         // Register port
  input  wire logic [31:0] rdata_o,       // Read data
  input  wire logic [31:0] value_i,       // Monitored value
  input  wire logic        value_vld_i,   // Evaluation strobe
  input  wire logic        motor_start_i, // Start pulse
  input  wire logic        running_i,     // Running level
  input  wire logic        status_o,      // Status
  input  wire logic        warn_o,        // Warning
  input  wire logic        fault_o,       // Fault
  input  wire logic        irq_o          // Interrupt
);
  // ----------------------------------------------------------------
  // Shadow of CTRL
  // ----------------------------------------------------------------
  logic [3:0] mode_ff; // Mode last written
  logic [1:0] act_ff;  // Action last written

  // Snoop writes; same edge as the design takes them
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_ff <= 4'h0;
      act_ff  <= 2'h0;
    end
    else if (bus_i.wr && bus_i.addr == SLS_OFS_CTRL)
    begin
      mode_ff <= bus_i.wdata[3:0];
      act_ff  <= bus_i.wdata[5:4];
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  unused_quiet_a: assert property ((mode_ff == 4'h0 || mode_ff > 4'h9) |-> !status_o)
    else $error("status set while channel unused");
  ctrl_clear_a: assert property (bus_i.wr && bus_i.addr == SLS_OFS_CTRL |=> !status_o)
    else $error("status kept over mode write");
  rise_cause_a: assert property ($rose(status_o) |-> $past(value_vld_i, 2))
    else $error("status rose without strobe");
  warn_map_a: assert property (status_o && act_ff == SLS_ACT_WARN |=> warn_o && !fault_o)
    else $error("warning not raised");
  fault_map_a: assert property (status_o && act_ff == SLS_ACT_FAULT |=> fault_o && !warn_o)
    else $error("fault not raised");
  fault_run_a: assert property (status_o && act_ff == SLS_ACT_FAULT_RUN && running_i |=> fault_o)
    else $error("running fault not raised");
  idle_run_a: assert property (act_ff == SLS_ACT_FAULT_RUN && !running_i |=> !fault_o && !warn_o)
    else $error("fault while stopped");
  no_action_a: assert property (!status_o || act_ff == SLS_ACT_NONE |=> !warn_o && !fault_o)
    else $error("action without cause");
  start_clear_a: assert property (motor_start_i && (mode_ff == 4'h8 || mode_ff == 4'h9) |=> !status_o)
    else $error("start did not clear status");

  // Main scenarios reached
  cover property ($rose(status_o));
  cover property (motor_start_i && status_o);
  cover property ($fell(status_o) && !$past(value_vld_i, 2));
endmodule

// ===== testbench/sls_drive_model.sv
// Drive control logic model: monitored value, strobe, start, running.
// Assumes the supervisor samples on the same core clock.
`timescale 1ns/100ps

module sls_drive_model
(
  input  wire logic  core_clk_i,    // Core clock
  output logic [31:0] value_o,      // Monitored value
  output logic        value_vld_o,  // Evaluation strobe
  output logic        motor_start_o,// Start event
  output logic        running_o     // Running level
);
  // Quiet at time zero
  initial
  begin
    value_o       = 32'h0000_0000;
    value_vld_o   = 1'b0;
    motor_start_o = 1'b0;
    running_o     = 1'b0;
  end

  // One strobe; afterwards the value is scrambled, since it is stale
  task automatic sample(input logic [31:0] v);
    @(posedge core_clk_i);
    value_o     <= v;
    value_vld_o <= 1'b1;
    @(posedge core_clk_i);
    value_o     <= ~v;
    value_vld_o <= 1'b0;
  endtask

  // One-cycle start command
  task automatic start_pulse();
    @(posedge core_clk_i);
    motor_start_o <= 1'b1;
    @(posedge core_clk_i);
    motor_start_o <= 1'b0;
  endtask

  // Running level change
  task automatic set_run(input logic r);
    @(posedge core_clk_i);
    running_o <= r;
  endtask
endmodule

// ===== testbench/signal_limit_supervisor_test.sv
// Self-checking bench for the signal limit supervisor.
// Assumes sls_pkg, the drive model and the checker are compiled first.
`timescale 1ns/100ps

module signal_limit_supervisor_test
  import sls_pkg::*;
;
  localparam int TK = 4; // Short delay tick keeps the run brief

  logic        clk;    // Core clock
  logic        rst;    // Reset
  sls_bus_t    bus;    // Register request
  logic [31:0] rdata;  // Read data
  logic [31:0] value;  // Monitored value
  logic        vld;    // Strobe
  logic        start;  // Start pulse
  logic        run_w;  // Running level
  logic        status; // Status
  logic        warn;   // Warning
  logic        fault;  // Fault
  logic        irq;    // Interrupt
  int          failures;
  int          tests_run;
  int          m_cond, m_arm, mode, act, lo, hi, hy; // Reference model state
  logic        run;    // Running level given to the model
  logic [15:0] seed;   // Random state

  sls_supervisor #(.TICK_CYCLES(TK)) dut_u (
    .core_clk_i(clk), .rst_i(rst), .bus_i(bus), .rdata_o(rdata), .value_i(value), .value_vld_i(vld),
    .motor_start_i(start), .running_i(run_w), .status_o(status), .warn_o(warn), .fault_o(fault), .irq_o(irq));

  sls_drive_model drv_u (
    .core_clk_i(clk), .value_o(value), .value_vld_o(vld), .motor_start_o(start), .running_o(run_w));

  // 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic int mag(input int x);
    return x < 0 ? -x : x;
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    chk(n, e, rdata);
  endtask

  // Mode write also clears condition and arming
  task automatic setm(input int m, input int a);
    wr(SLS_OFS_CTRL, {26'h0, 2'(a), 4'(m)});
    mode   = m;
    act    = a;
    m_cond = 0;
    m_arm  = 0;
  endtask

  // Reference comparison, doubled to keep half hysteresis exact
  task automatic model(input int v);
    int a, l2, h2, s, c;
    a  = 2 * v;
    l2 = 2 * lo;
    h2 = 2 * hi;
    s  = 0;
    c  = 0;
    if (mode == 3 || mode == 4 || mode == 6)
    begin
      a  = 2 * mag(v);
      l2 = 2 * mag(lo);
      h2 = 2 * mag(hi);
    end
    case (mode)
      1, 3: begin s = a < l2 - hy; c = a > l2 + hy; end
      2, 4: begin s = a > h2 + hy; c = a < h2 - hy; end
      5, 6: begin s = a > h2 + hy || a < l2 - hy; c = a < h2 - hy && a > l2 + hy; end
      7:    begin s = a > h2 + hy; c = a < l2 - hy; end
      8:    begin s = m_arm && a < l2 - hy; c = a > l2 + hy; if (c) m_arm = 1; if (a < l2 - hy) m_arm = 0; end
      9:    begin s = m_arm && a > h2 + hy; c = a < h2 - hy; if (c) m_arm = 1; if (a > h2 + hy) m_arm = 0; end
      default: c = 1;
    endcase
    if (s)
      m_cond = 1;
    else if (c)
      m_cond = 0;
  endtask

  // One evaluation, then status and action compared once settled
  task automatic ev(input int v);
    drv_u.sample(32'(v));
    model(v);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("status", 32'(m_cond), 32'(status));
    chk("warn", 32'(m_cond != 0 && act == 1), 32'(warn));
    chk("fault", 32'(m_cond != 0 && (act == 2 || (act == 3 && run))), 32'(fault));
  endtask

  task automatic print_verdict();
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    bus       = '0;
    rst       = 1'b1;
    failures  = 0;
    tests_run = 0;
    lo        = -20;
    hi        = 30;
    hy        = 6;
    run       = 1'b0;
    seed      = 16'h5493; // Starts at 21651
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // Reset values, unmapped word at the end
    for (int a = 0; a <= 32; a += 4) rchk("reset", 8'(a), 32'h0000_0000);
    wr(SLS_OFS_HYST, 32'hFFFF_FFFF);
    rchk("hyst", SLS_OFS_HYST, 32'h7FFF_FFFF);
    wr(SLS_OFS_STATE, 32'hFFFF_FFFF);
    rchk("state", SLS_OFS_STATE, 32'h0000_0000);
    wr(SLS_OFS_LOW, 32'(lo));
    wr(SLS_OFS_HIGH, 32'(hi));
    wr(SLS_OFS_HYST, 32'(hy));
    rchk("low", SLS_OFS_LOW, 32'(lo));
    // Every mode, reserved code 10 too, rotating action codes
    for (int m = 0; m <= 10; m++)
    begin
      setm(m, m % 4);
      seed = lfsr(seed);
      run  = seed[0];
      drv_u.set_run(run);
      repeat (24)
      begin
        seed = lfsr(seed);
        ev(int'(seed % 16'd121) - 60);
      end
    end
    // Start command clears the crossing action at once
    run = 1'b0;
    drv_u.set_run(run);
    setm(8, 3);
    ev(50);
    ev(-50);
    drv_u.start_pulse();
    @(negedge clk);
    m_cond = 0;
    m_arm  = 0;
    chk("start", 32'h0000_0000, 32'(status));
    ev(-50);
    ev(50);
    ev(-50);
    // Off delay of three counts, then an aborted countdown
    run = 1'b1;
    drv_u.set_run(run);
    setm(2, 3);
    wr(SLS_OFS_OFFDLY, 32'h0000_0003);
    ev(50);
    drv_u.sample(32'h0000_0000);
    model(0);
    repeat (3 * TK) @(posedge clk);
    @(negedge clk);
    chk("hold", 32'h0000_0001, 32'(status));
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("release", 32'h0000_0000, 32'(status));
    ev(50);
    drv_u.sample(32'h0000_0000);
    model(0);
    repeat (TK) @(posedge clk);
    ev(50);
    repeat (4 * TK) @(posedge clk);
    @(negedge clk);
    chk("abort", 32'h0000_0001, 32'(status));
    wr(SLS_OFS_OFFDLY, 32'h0000_0000);
    // Mode rewrite drops status, then interrupt raise, mask, clear
    setm(2, 0);
    @(negedge clk);
    chk("modewr", 32'h0000_0000, 32'(status));
    wr(SLS_OFS_IRQSTS, 32'h0000_0003);
    ev(50);
    chk("irq masked", 32'h0000_0000, 32'(irq));
    rchk("irq sts", SLS_OFS_IRQSTS, 32'h0000_0001);
    wr(SLS_OFS_IRQMSK, 32'h0000_0001);
    @(negedge clk);
    chk("irq on", 32'h0000_0001, 32'(irq));
    wr(SLS_OFS_IRQSTS, 32'h0000_0001);
    @(negedge clk);
    chk("irq clr", 32'h0000_0000, 32'(irq));
    ev(0);
    rchk("irq off", SLS_OFS_IRQSTS, 32'h0000_0002);
    chk("irq off", 32'h0000_0000, 32'(irq));
    print_verdict();
  end
endmodule

bind sls_supervisor sls_checker chk_u (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o), .value_i(value_i),
  .value_vld_i(value_vld_i), .motor_start_i(motor_start_i), .running_i(running_i), .status_o(status_o),
  .warn_o(warn_o), .fault_o(fault_o), .irq_o(irq_o));
